// >>> src/fetch_seq_pkg.sv
/*
  Constants for the instruction fetch and program counter sequencer:
  data-space offsets, vectors, phase numbers, start-up timing, state codes.
  Assumes a single 40 MHz system clock that also serves as the core clock.
*/
// What this block does
// - System clock splits into four phases; one instruction cycle is four clocks.
// - Next instruction is fetched while the previous one executes.
// - Instructions that change the counter take two cycles with a dummy refill.
// - Counter advances by one after every program word fetch except a lookup read.
// - Taken skip discards the fetched word; counter effectively advances by two.
// - Low counter byte at 06H; write keeps bits 9..8, short jump in page.
// - Counter loads a target on every transfer kind instead of incrementing.
// - Jump and call load all ten counter bits from the instruction word.
// - Return reloads all ten counter bits from the top stack entry.
// - Reset clears the counter so execution starts at 000H.
// - Enabled external interrupt with stack not full vectors to 004H.
// - Enabled timer overflow interrupt with stack not full vectors to 008H.
// - Program memory is 1024 x 14, addressed by counter or lookup pointer.
// - Current-page read uses counter bits 9..8; last-page read forces them to one.
// - Lookup low byte goes to data memory; six high bits to read-only 08H.
// - Lookup pointer is a read/write register at 07H set before reads.
// - Every lookup read instruction takes two instruction cycles.
// - Wake-up from halt holds execution for 1024 system clock periods.
// - Call and interrupt push the counter on a four-level stack; returns pop it.
// - With the stack full, an enabled interrupt waits until a return pops.

package fetch_seq_pkg;

  // ----------------------------------------------------------------
  // Data-space register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] LOW_BYTE_ADDR = 8'h06;
  localparam logic [7:0] LOOKUP_PTR_ADDR = 8'h07;
  localparam logic [7:0] LOOKUP_HIGH_ADDR = 8'h08;
  localparam logic [7:0] LOW_BYTE_RESET = 8'h00;
  localparam logic [7:0] LOOKUP_PTR_RESET = 8'h00;
  localparam logic [5:0] LOOKUP_HIGH_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Program memory geometry and vectors
  // ----------------------------------------------------------------
  localparam int PC_W = 10;
  localparam int WORD_W = 14;
  localparam logic [9:0] RESET_VECTOR = 10'h000;
  localparam logic [9:0] EXT_VECTOR = 10'h004;
  localparam logic [9:0] TMR_VECTOR = 10'h008;
  localparam logic [1:0] LAST_PAGE = 2'h3;
  localparam int STACK_DEPTH = 4;

  // ----------------------------------------------------------------
  // Instruction cycle phases
  // ----------------------------------------------------------------
  localparam logic [1:0] PH_FETCH = 2'h0;
  localparam logic [1:0] PH_CAPTURE = 2'h1;
  localparam logic [1:0] PH_LAST = 2'h3;

  // ----------------------------------------------------------------
  // Start-up timer after wake-up
  // ----------------------------------------------------------------
  localparam int SST_PERIODS = 1024;
  localparam int SYS_PERIOD_NS = 25;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SST_CYCLES = (SST_PERIODS * SYS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Run state of the sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_START = 2'b10
  } run_state_t;

endpackage

// >>> src/return_stack.sv
/*
  Return address stack for calls and interrupts.
  Assumes push and pop are single-cycle pulses and never both at once.
*/
`timescale 1ns/1ps
`default_nettype none

module return_stack #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 10
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Stack operations
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [WIDTH-1:0] i_push_value,
  // Status
  output logic [WIDTH-1:0] o_top,
  output logic o_full
);

  logic [WIDTH-1:0] entry_q [DEPTH];
  logic [$clog2(DEPTH+1)-1:0] count_q;

  // ----------------------------------------------------------------
  // Storage: a shift register, so an overflowing push drops the oldest
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_entry
      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          entry_q[g] <= '0;
        end else if (i_push) begin
          entry_q[g] <= (g == 0) ? i_push_value : entry_q[(g == 0) ? 0 : g-1];
        end else if (i_pop) begin
          entry_q[g] <= (g == DEPTH-1) ? '0 : entry_q[(g == DEPTH-1) ? g : g+1];
        end
      end
    end
  endgenerate

  // Fill level saturates at the depth
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      count_q <= '0;
    end else if (i_push && !o_full) begin
      count_q <= count_q + 1'b1;
    end else if (i_pop && count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign o_top = entry_q[0];
  assign o_full = (count_q == DEPTH[$clog2(DEPTH+1)-1:0]);

endmodule // return_stack

`default_nettype wire

// >>> src/program_counter_fetch_sequencer.sv
/*
  Fetch and program counter sequencer: four-phase instruction cycle,
  fetch/execute overlap, transfers, skips, lookup reads, vectors, halt.
  Assumes the execute unit asserts its command inputs in phase 3 of the
  cycle in which o_exec_valid is high, and that interrupt requests come
  already enabled and prioritised from the interrupt controller.
*/
`timescale 1ns/1ps
`default_nettype none

module program_counter_fetch_sequencer #(
  parameter int SST_COUNT = fetch_seq_pkg::SST_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Program memory read port, data one clock after the strobe
  output logic [9:0] o_pmem_addr,
  output logic o_pmem_rd,
  input wire logic [13:0] i_pmem_data,
  // Register port in data space
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Instruction handed to the execute unit
  output logic [13:0] o_exec_word,
  output logic [9:0] o_exec_pc,
  output logic o_exec_valid,
  output logic [1:0] o_phase,
  // Commands from the execute unit, valid in the last phase
  input wire logic i_jump,
  input wire logic i_call,
  input wire logic i_ret,
  input wire logic i_skip,
  input wire logic i_read_cur,
  input wire logic i_read_last,
  input wire logic [7:0] i_read_dest,
  input wire logic i_halt,
  // Lookup result write into data memory
  output logic [7:0] o_dmem_addr,
  output logic [7:0] o_dmem_wdata,
  output logic o_dmem_wr,
  // Interrupt requests and acknowledges
  input wire logic i_ext_irq,
  input wire logic i_tmr_irq,
  output logic o_ext_ack,
  output logic o_tmr_ack,
  // Wake-up request while halted
  input wire logic i_wake,
  output logic o_halted
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fetch_seq_pkg::run_state_t state_q;
  logic [1:0] phase_q;
  logic [12:0] sst_cnt_q;
  logic [9:0] pc_q;
  logic [9:0] pc_d;
  logic [9:0] fetch_pc_q;
  logic [13:0] fetch_word_q;
  logic [13:0] exec_word_q;
  logic [9:0] exec_pc_q;
  logic exec_valid_q;
  logic [9:0] pmem_addr_q;
  logic [9:0] pmem_addr_d;
  logic [7:0] lookup_ptr_q;
  logic [5:0] lookup_high_q;
  logic [7:0] low_byte_val_q;
  logic low_byte_pend_q;
  logic read_pend_q;
  logic [9:0] read_addr_q;
  logic [7:0] read_dest_q;
  logic [7:0] rdata_q;
  logic dmem_wr_q;
  logic [7:0] dmem_addr_q;
  logic [7:0] dmem_wdata_q;
  logic ext_ack_q;
  logic tmr_ack_q;
  logic running;
  logic cycle_end;
  logic xfer;
  logic read_start;
  logic push;
  logic pop;
  logic [9:0] push_value;
  logic take_ext;
  logic take_tmr;
  logic [9:0] stack_top;
  logic stack_full;

  // ----------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------
  return_stack #(
    .DEPTH(fetch_seq_pkg::STACK_DEPTH),
    .WIDTH(fetch_seq_pkg::PC_W)
  ) u_stack (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_push(push),
    .i_pop(pop),
    .i_push_value(push_value),
    .o_top(stack_top),
    .o_full(stack_full)
  );

  // ----------------------------------------------------------------
  // Run control: halt, wake-up and start-up hold-off
  // ----------------------------------------------------------------
  assign running = (state_q == fetch_seq_pkg::ST_RUN);
  assign cycle_end = running && (phase_q == fetch_seq_pkg::PH_LAST);

  // Halt only takes effect at a cycle boundary
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= fetch_seq_pkg::ST_RUN;
      sst_cnt_q <= '0;
    end else begin
      case (state_q)
        fetch_seq_pkg::ST_RUN: begin
          if (cycle_end && exec_valid_q && i_halt) begin
            state_q <= fetch_seq_pkg::ST_HALT;
          end
        end
        fetch_seq_pkg::ST_HALT: begin
          if (i_wake) begin
            state_q <= fetch_seq_pkg::ST_START;
            sst_cnt_q <= 13'(SST_COUNT - 1);
          end
        end
        fetch_seq_pkg::ST_START: begin
          if (sst_cnt_q == '0) begin
            state_q <= fetch_seq_pkg::ST_RUN;
          end else begin
            sst_cnt_q <= sst_cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= fetch_seq_pkg::ST_RUN;
        end
      endcase
    end
  end

  // Phase counter; frozen outside the run state
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      phase_q <= fetch_seq_pkg::PH_FETCH;
    end else if (running) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Next counter and end-of-cycle decision
  // ----------------------------------------------------------------
  // Execute-unit transfers win over interrupts; an interrupt then
  // waits one cycle, which keeps push and pop from meeting.
  always_comb begin
    pc_d = pc_q;
    xfer = 1'b0;
    read_start = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    push_value = fetch_pc_q;
    take_ext = 1'b0;
    take_tmr = 1'b0;
    if (cycle_end && !read_pend_q) begin
      if (exec_valid_q && (i_jump || i_call)) begin
        pc_d = exec_word_q[9:0];
        xfer = 1'b1;
        push = i_call;
      end else if (exec_valid_q && i_ret) begin
        pc_d = stack_top;
        xfer = 1'b1;
        pop = 1'b1;
      end else if (exec_valid_q && i_skip) begin
        pc_d = exec_pc_q + 10'h002;
        xfer = 1'b1;
      end else if (low_byte_pend_q) begin
        pc_d = {pc_q[9:8], low_byte_val_q};
        xfer = 1'b1;
      end else if (exec_valid_q && (i_read_cur || i_read_last)) begin
        read_start = 1'b1;
      end else if ((i_ext_irq || i_tmr_irq) && !stack_full) begin
        take_ext = i_ext_irq;
        take_tmr = !i_ext_irq;
        pc_d = i_ext_irq ? fetch_seq_pkg::EXT_VECTOR : fetch_seq_pkg::TMR_VECTOR;
        xfer = 1'b1;
        push = 1'b1;
      end
    end
  end

  // Address of the next program memory access
  always_comb begin
    pmem_addr_d = pc_d;
    if (read_start) begin
      if (i_read_last) begin
        pmem_addr_d = {fetch_seq_pkg::LAST_PAGE, lookup_ptr_q};
      end else begin
        pmem_addr_d = {pc_q[9:8], lookup_ptr_q};
      end
    end
  end

  // ----------------------------------------------------------------
  // Program counter and fetch stage
  // ----------------------------------------------------------------
  // Counter steps once per fetched word, skipped in lookup cycles
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pc_q <= fetch_seq_pkg::RESET_VECTOR;
      fetch_pc_q <= fetch_seq_pkg::RESET_VECTOR;
      fetch_word_q <= '0;
    end else if (running && phase_q == fetch_seq_pkg::PH_CAPTURE && !read_pend_q) begin
      fetch_word_q <= i_pmem_data;
      fetch_pc_q <= pc_q;
      pc_q <= pc_q + 10'h001;
    end else if (cycle_end && xfer) begin
      pc_q <= pc_d;
    end
  end

  // Memory address, registered and changed only at cycle ends
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pmem_addr_q <= fetch_seq_pkg::RESET_VECTOR;
    end else if (cycle_end) begin
      pmem_addr_q <= pmem_addr_d;
    end
  end

  assign o_pmem_addr = pmem_addr_q;
  assign o_pmem_rd = running && (phase_q == fetch_seq_pkg::PH_FETCH);

  // ----------------------------------------------------------------
  // Execute stage
  // ----------------------------------------------------------------
  // A transfer or lookup turns the next cycle into a dummy refill
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      exec_word_q <= '0;
      exec_pc_q <= fetch_seq_pkg::RESET_VECTOR;
      exec_valid_q <= 1'b0;
    end else if (cycle_end) begin
      if (xfer || read_start) begin
        exec_valid_q <= 1'b0;
      end else begin
        exec_word_q <= fetch_word_q;
        exec_pc_q <= fetch_pc_q;
        exec_valid_q <= 1'b1;
      end
    end
  end

  assign o_exec_word = exec_word_q;
  assign o_exec_pc = exec_pc_q;
  assign o_exec_valid = exec_valid_q && running;
  assign o_phase = phase_q;
  assign o_halted = !running;

  // ----------------------------------------------------------------
  // Lookup reads
  // ----------------------------------------------------------------
  // The already fetched word is held through the lookup cycle
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      read_pend_q <= 1'b0;
      read_addr_q <= '0;
      read_dest_q <= '0;
    end else if (cycle_end) begin
      read_pend_q <= read_start;
      if (read_start) begin
        read_addr_q <= pmem_addr_d;
        read_dest_q <= i_read_dest;
      end
    end
  end

  // Result capture: low byte to data memory, high bits kept here
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      lookup_high_q <= fetch_seq_pkg::LOOKUP_HIGH_RESET;
      dmem_wr_q <= 1'b0;
      dmem_addr_q <= '0;
      dmem_wdata_q <= '0;
    end else begin
      dmem_wr_q <= 1'b0;
      if (running && phase_q == fetch_seq_pkg::PH_CAPTURE && read_pend_q) begin
        lookup_high_q <= i_pmem_data[13:8];
        dmem_wr_q <= 1'b1;
        dmem_addr_q <= read_dest_q;
        dmem_wdata_q <= i_pmem_data[7:0];
      end
    end
  end

  assign o_dmem_wr = dmem_wr_q;
  assign o_dmem_addr = dmem_addr_q;
  assign o_dmem_wdata = dmem_wdata_q;

  // ----------------------------------------------------------------
  // Interrupt acknowledges
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ext_ack_q <= 1'b0;
      tmr_ack_q <= 1'b0;
    end else begin
      ext_ack_q <= take_ext;
      tmr_ack_q <= take_tmr;
    end
  end

  assign o_ext_ack = ext_ack_q;
  assign o_tmr_ack = tmr_ack_q;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  // Lookup pointer; software loads it before issuing a lookup
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      lookup_ptr_q <= fetch_seq_pkg::LOOKUP_PTR_RESET;
    end else if (i_reg_wr && i_reg_addr == fetch_seq_pkg::LOOKUP_PTR_ADDR) begin
      lookup_ptr_q <= i_reg_wdata;
    end
  end

  // Low-byte write is held until the cycle end; a new write wins
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      low_byte_pend_q <= 1'b0;
      low_byte_val_q <= fetch_seq_pkg::LOW_BYTE_RESET;
    end else if (i_reg_wr && i_reg_addr == fetch_seq_pkg::LOW_BYTE_ADDR) begin
      low_byte_pend_q <= 1'b1;
      low_byte_val_q <= i_reg_wdata;
    end else if (cycle_end && !read_pend_q && !(exec_valid_q && (i_jump || i_call || i_ret
                 || i_skip))) begin
      low_byte_pend_q <= 1'b0;
    end
  end

  // Read data one clock after the strobe; unmapped offsets read zero
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_q <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        fetch_seq_pkg::LOW_BYTE_ADDR: rdata_q <= exec_pc_q[7:0];
        fetch_seq_pkg::LOOKUP_PTR_ADDR: rdata_q <= lookup_ptr_q;
        fetch_seq_pkg::LOOKUP_HIGH_ADDR: rdata_q <= {2'h0, lookup_high_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign o_reg_rdata = rdata_q;

endmodule // program_counter_fetch_sequencer

`default_nettype wire

// >>> verif/fetch_seq_properties.sv
/*
  Timing properties of the fetch sequencer, bound to its top ports.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fetch_seq_properties (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Fetch and execute side
  input wire logic [9:0] o_pmem_addr,
  input wire logic o_pmem_rd,
  input wire logic [13:0] o_exec_word,
  input wire logic [9:0] o_exec_pc,
  input wire logic o_exec_valid,
  input wire logic [1:0] o_phase,
  input wire logic o_halted,
  // Commands
  input wire logic i_jump,
  input wire logic i_call,
  input wire logic i_ret,
  input wire logic i_skip,
  input wire logic i_read_cur,
  input wire logic i_read_last,
  input wire logic [7:0] i_read_dest,
  // Registers, lookup writes, interrupts
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_dmem_wr,
  input wire logic [7:0] o_dmem_addr,
  input wire logic i_ext_irq,
  input wire logic i_tmr_irq,
  input wire logic o_ext_ack,
  input wire logic o_tmr_ack
);
  // ----------------------------------------------------------------
  // Helpers and properties
  // ----------------------------------------------------------------
  logic last_ph;
  logic lookup;
  logic [9:0] target;
  // Commands only count in the last phase of a live instruction
  assign last_ph = o_phase == fetch_seq_pkg::PH_LAST && o_exec_valid;
  assign lookup = i_read_cur | i_read_last;
  assign target = o_exec_word[9:0];
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_phase_step: assert property (!o_halted && !$past(o_halted) && !$past(i_reset)
    |-> o_phase == $past(o_phase) + 2'h1) else $error("phase did not advance");
  a_fetch_strobe: assert property (o_pmem_rd == (o_phase == fetch_seq_pkg::PH_FETCH && !o_halted))
    else $error("fetch strobe outside phase 0");
  a_addr_hold: assert property ($past(o_phase) != fetch_seq_pkg::PH_LAST && !$past(i_reset)
    |-> $stable(o_pmem_addr)) else $error("fetch address moved mid cycle");
  a_seq_pc: assert property (o_phase == 2'h0 && o_exec_valid && $past(o_exec_valid, 4)
    && !$past(o_halted, 4) |-> o_exec_pc == $past(o_exec_pc, 4) + 10'h001)
    else $error("sequential pc not plus one");
  a_jump_load: assert property (last_ph && (i_jump || i_call) |=> o_pmem_addr == $past(target)
    && !o_exec_valid ##4 o_exec_valid && o_exec_pc == $past(target, 5))
    else $error("jump target or refill wrong");
  a_skip_dummy: assert property (last_ph && i_skip && !(i_jump || i_call || i_ret) |=>
    !o_exec_valid [*4] ##1 o_exec_valid && o_exec_pc == $past(o_exec_pc, 5) + 10'h002)
    else $error("skip did not discard one word");
  a_ext_vector: assert property (o_ext_ack |-> o_pmem_addr == fetch_seq_pkg::EXT_VECTOR
    && !o_exec_valid && $past(i_ext_irq)) else $error("external vector wrong");
  a_tmr_vector: assert property (o_tmr_ack |-> o_pmem_addr == fetch_seq_pkg::TMR_VECTOR
    && !o_exec_valid && $past(i_tmr_irq)) else $error("timer vector wrong");
  a_last_page: assert property (last_ph && i_read_last && !(i_jump || i_call || i_ret || i_skip)
    |=> o_pmem_addr[9:8] == fetch_seq_pkg::LAST_PAGE) else $error("last page not forced");
  a_lookup_write: assert property (o_dmem_wr |-> $past(lookup, 3)
    && o_dmem_addr == $past(i_read_dest, 3)) else $error("lookup byte misplaced");
  a_read_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_reset_vector: assert property ($past(i_reset) |-> o_pmem_addr == fetch_seq_pkg::RESET_VECTOR
    && !o_exec_valid) else $error("reset did not clear pc");
endmodule // fetch_seq_properties

bind program_counter_fetch_sequencer fetch_seq_properties u_fetch_seq_properties (
  .i_clk, .i_reset, .o_pmem_addr, .o_pmem_rd, .o_exec_word, .o_exec_pc, .o_exec_valid,
  .o_phase, .o_halted, .i_jump, .i_call, .i_ret, .i_skip, .i_read_cur, .i_read_last,
  .i_read_dest, .i_reg_rd, .o_reg_rdata, .o_dmem_wr, .o_dmem_addr, .i_ext_irq, .i_tmr_irq,
  .o_ext_ack, .o_tmr_ack);
`default_nettype wire

// >>> verif/fetch_mem_model.sv
/*
  Program and data memory beside the sequencer.
  Assumes the word is strobed one clock before it is sampled.
*/
`timescale 1ns/1ps
`default_nettype none
module fetch_mem_model (
  // Clock
  input wire logic i_clk,
  // Program memory port
  input wire logic [9:0] i_addr,
  input wire logic i_rd,
  output logic [13:0] o_data,
  // Data memory write port
  input wire logic i_wr,
  input wire logic [7:0] i_waddr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_last_addr,
  output logic [7:0] o_last_data
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Word is a pattern of its address; toggles when not read so stale data shows
  always_ff @(posedge i_clk) begin
    if (i_rd) o_data <= {4'hC, ~i_addr};
    else o_data <= ~o_data;
  end
  // Keep the last lookup byte written
  always_ff @(posedge i_clk) begin
    if (i_wr) begin
      o_last_addr <= i_waddr;
      o_last_data <= i_wdata;
    end
  end
endmodule // fetch_mem_model
`default_nettype wire

// >>> verif/program_counter_fetch_sequencer_tb.sv
/*
  Self-checking bench for the fetch sequencer: commands per instruction,
  register accesses, interrupts and halt. Assumes the memory model alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module program_counter_fetch_sequencer_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int SST = 8;
  localparam logic [6:0] JMP = 7'h40, CAL = 7'h20, RET = 7'h10, SKP = 7'h08;
  localparam logic [6:0] RDC = 7'h04, RDL = 7'h02, HLT = 7'h01;
  logic i_clk, i_reset, i_reg_wr, i_reg_rd, i_jump, i_call, i_ret, i_skip, i_halt;
  logic i_read_cur, i_read_last, i_ext_irq, i_tmr_irq, i_wake;
  logic o_pmem_rd, o_exec_valid, o_dmem_wr, o_ext_ack, o_tmr_ack, o_halted;
  logic [7:0] i_reg_addr, i_reg_wdata, i_read_dest, o_reg_rdata, o_dmem_addr, o_dmem_wdata;
  logic [7:0] dm_addr, dm_data;
  logic [9:0] o_pmem_addr, o_exec_pc;
  logic [13:0] i_pmem_data, o_exec_word;
  logic [1:0] o_phase;
  int failures, total_checks, cyc_n, last_n, ext_n, tmr_n, n;

  program_counter_fetch_sequencer #(.SST_COUNT(SST)) u_program_counter_fetch_sequencer (
    .i_clk(i_clk), .i_reset(i_reset), .o_pmem_addr(o_pmem_addr), .o_pmem_rd(o_pmem_rd),
    .i_pmem_data(i_pmem_data), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_exec_word(o_exec_word), .o_exec_pc(o_exec_pc), .o_exec_valid(o_exec_valid),
    .o_phase(o_phase), .i_jump(i_jump), .i_call(i_call), .i_ret(i_ret), .i_skip(i_skip),
    .i_read_cur(i_read_cur), .i_read_last(i_read_last), .i_read_dest(i_read_dest),
    .i_halt(i_halt), .o_dmem_addr(o_dmem_addr), .o_dmem_wdata(o_dmem_wdata),
    .o_dmem_wr(o_dmem_wr), .i_ext_irq(i_ext_irq), .i_tmr_irq(i_tmr_irq),
    .o_ext_ack(o_ext_ack), .o_tmr_ack(o_tmr_ack), .i_wake(i_wake), .o_halted(o_halted));
  fetch_mem_model u_fetch_mem_model (
    .i_clk(i_clk), .i_addr(o_pmem_addr), .i_rd(o_pmem_rd), .o_data(i_pmem_data),
    .i_wr(o_dmem_wr), .i_waddr(o_dmem_addr), .i_wdata(o_dmem_wdata),
    .o_last_addr(dm_addr), .o_last_data(dm_data));

  // Clock at 40 MHz
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // Cycle count, acknowledge tally and hang guard
  always @(posedge i_clk) begin
    cyc_n <= cyc_n + 1;
    if (o_ext_ack === 1'b1) ext_n <= ext_n + 1;
    if (o_tmr_ack === 1'b1) tmr_n <= tmr_n + 1;
    if (cyc_n > 5000) begin
      failures++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [13:0] got, input logic [13:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Write takes an extra edge so back-to-back strobes never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(posedge i_clk);
    check({6'h00, o_reg_rdata}, {6'h00, exp}, "reg read");
  endtask
  // Waits for the last phase of a live instruction and issues its command
  task automatic step(input logic [6:0] cmd, input logic [7:0] dest, input logic [9:0] pc,
                      input int gap);
    int k;
    k = 0;
    @(posedge i_clk);
    while (!(o_phase === 2'h2 && o_exec_valid === 1'b1) && k < 40) begin
      k++;
      @(posedge i_clk);
    end
    check({4'h0, o_exec_pc}, {4'h0, pc}, "exec pc");
    check(o_exec_word, {4'hC, ~pc}, "exec word");
    if (gap > 0) check(14'(cyc_n - last_n), 14'(gap), "cycle gap");
    last_n = cyc_n;
    {i_jump, i_call, i_ret, i_skip, i_read_cur, i_read_last, i_halt} <= cmd;
    i_read_dest <= dest;
    @(posedge i_clk);
    {i_jump, i_call, i_ret, i_skip, i_read_cur, i_read_last, i_halt} <= 7'h00;
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence: at most one register access fits between two steps
  // ----------------------------------------------------------------
  initial begin
    {i_reset, i_reg_wr, i_reg_rd, i_jump, i_call, i_ret, i_skip, i_halt} = 8'hFF;
    {i_reg_wr, i_reg_rd, i_jump, i_call, i_ret, i_skip, i_halt} = 7'h00;
    {i_read_cur, i_read_last, i_ext_irq, i_tmr_irq, i_wake} = 5'h00;
    {i_reg_addr, i_reg_wdata, i_read_dest} = 24'h000000;
    {failures, total_checks, cyc_n, last_n, ext_n, tmr_n} = '0;
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    step(7'h00, 8'h00, 10'h000, 0);
    rd(8'h07, 8'h00);
    step(7'h00, 8'h00, 10'h001, 4);
    rd(8'h08, 8'h00);
    i_tmr_irq <= 1'b1;
    step(7'h00, 8'h00, 10'h002, 4);
    i_tmr_irq <= 1'b0;
    rd(8'h20, 8'h00);
    step(RET, 8'h00, 10'h008, 8);
    step(CAL, 8'h00, 10'h003, 8);
    step(CAL, 8'h00, 10'h3FC, 8);
    step(CAL, 8'h00, 10'h003, 8);
    step(CAL, 8'h00, 10'h3FC, 8);
    i_ext_irq <= 1'b1;
    step(7'h00, 8'h00, 10'h003, 8);
    step(RET, 8'h00, 10'h004, 4);
    step(RET, 8'h00, 10'h004, 12);
    i_ext_irq <= 1'b0;
    step(JMP, 8'h00, 10'h3FD, 8);
    wr(8'h07, 8'h3C);
    step(RDC, 8'h51, 10'h002, 8);
    step(7'h00, 8'h00, 10'h003, 8);
    check({dm_data, dm_addr[5:0]}, {8'hC3, 6'h11}, "current page byte");
    rd(8'h08, 8'h33);
    step(RDL, 8'h52, 10'h004, 4);
    step(7'h00, 8'h00, 10'h005, 8);
    check({dm_data, dm_addr[5:0]}, {8'hC3, 6'h12}, "last page byte");
    rd(8'h08, 8'h30);
    step(SKP, 8'h00, 10'h006, 4);
    wr(8'h08, 8'hFF);
    step(JMP, 8'h00, 10'h008, 8);
    rd(8'h08, 8'h30);
    step(7'h00, 8'h00, 10'h3F7, 8);
    wr(8'h06, 8'h40);
    step(7'h00, 8'h00, 10'h3F8, 4);
    step(7'h00, 8'h00, 10'h340, 8);
    rd(8'h06, 8'h41);
    step(HLT, 8'h00, 10'h341, 4);
    repeat (3) @(posedge i_clk);
    check({13'h0000, o_halted}, 14'h0001, "halted");
    i_wake <= 1'b1;
    n = 0;
    while (o_halted !== 1'b0 && n < 40) begin
      @(posedge i_clk);
      n++;
    end
    check(14'(n >= SST && n <= SST + 3), 14'h0001, "start-up delay");
    i_wake <= 1'b0;
    step(7'h00, 8'h00, 10'h342, 0);
    check(14'(ext_n), 14'h0001, "external acks");
    check(14'(tmr_n), 14'h0001, "timer acks");
    wrap_up();
  end
endmodule // program_counter_fetch_sequencer_tb
`default_nettype wire
